// ### common/exc_pkg.sv
package exc_pkg;

  localparam int          WORD_W        = 32;
  localparam int          FRAME_WORDS   = 8;
  localparam int          IRQ_N         = 16;
  localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
  localparam logic [31:0] FRAME_BYTES   = 32'h0000_0020;
  localparam logic [31:0] SP_RESET      = 32'h0000_0000;
  localparam logic [31:0] VTBASE_RESET  = 32'h0000_0000;
  localparam int          VTBASE_LSB    = 28;
  localparam int          VTBASE_MSB    = 31;
  localparam logic [31:0] VECTOR_STRIDE = 32'h0000_0004;
  localparam logic [3:0]  IRQ_EXC_BASE  = 4'h0;
  localparam logic [31:0] EXC_RET_PROC  = 32'hFFFF_FFFD;
  localparam logic [31:0] EXC_RET_MAIN  = 32'hFFFF_FFF9;

  // Push order: highest address first, so word 0 (general register 0) lands at the new SP
  typedef enum logic [2:0] {
    SLOT_R0, SLOT_R1, SLOT_R2, SLOT_R3, SLOT_R12, SLOT_LINK, SLOT_RETADDR, SLOT_STATUS
  } slot_type;

  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_SLEEP, PWR_DEEP
  } power_type;

endpackage : exc_pkg

// ### common/stack_mem_if.sv
`timescale 1ns/10ps
interface stack_mem_if;
  logic        req;
  logic        write;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        done;

  modport core (output req, output write, output addr, output wdata,
                input rdata, input done);
  modport port (input req, input write, input addr, input wdata,
                output rdata, output done);
endinterface : stack_mem_if

// ### design/exception_stacking_and_wakeup.sv
`timescale 1ns/10ps
module exception_stacking_and_wakeup #(
  parameter int IRQ_N = exc_pkg::IRQ_N
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Core register file view
  input  wire logic [31:0]      statusIn,
  input  wire logic [31:0]      retAddrIn,
  input  wire logic [31:0]      linkIn,
  input  wire logic [31:0]      r12In,
  input  wire logic [31:0]      r3In,
  input  wire logic [31:0]      r2In,
  input  wire logic [31:0]      r1In,
  input  wire logic [31:0]      r0In,
  // Control inputs from core
  input  wire logic             spSelect,
  input  wire logic             globalMaskBit,
  input  wire logic             vtBaseWrite,
  input  wire logic [3:0]       vtBaseData,
  input  wire logic             spWrite,
  input  wire logic             spWriteProc,
  input  wire logic [31:0]      spWriteData,
  input  wire logic             excReturn,
  input  wire logic             waitForInterrupt,
  input  wire logic             deepSleepSelect,
  // Interrupt sources (asynchronous)
  input  wire logic [IRQ_N-1:0] irqPending,
  input  wire logic [IRQ_N-1:0] irqEnable,
  input  wire logic [IRQ_N-1:0] irqConfigurable,
  input  wire logic             watchdogIrq,
  input  wire logic             fixedIrq,
  // Stack memory
  output      logic             memReq,
  output      logic             memWrite,
  output      logic [31:0]      memAddr,
  output      logic [31:0]      memWdata,
  input  wire logic             memAck,
  input  wire logic [31:0]      memRdata,
  // Results
  output      logic             handlerMode,
  output      logic [31:0]      activeSp,
  output      logic [31:0]      mainSp,
  output      logic [31:0]      processSp,
  output      logic [31:0]      vectorAddr,
  output      logic [4:0]       activeExc,
  output      logic             handlerStart,
  output      logic [1:0]       powerMode,
  output      logic             sleepRequest,
  output      logic             wakeup,
  output      logic [exc_pkg::WORD_W-1:0] popWord,
  output      logic             popValid
);
  localparam int FRAME_W = exc_pkg::WORD_W;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum { ST_IDLE, ST_PUSH, ST_WAITPUSH, ST_ENTER, ST_POP, ST_WAITPOP } phase_type;

  typedef struct packed {
    logic [IRQ_N+1:0] syncA;
    logic [IRQ_N+1:0] syncB;
    logic [31:0]      mainSp;
    logic [31:0]      processSp;
    logic [3:0]       vtBase;
    logic             handler;
    logic [2:0]       depth;
    logic [2:0]       slot;
    logic [31:0]      frameBase;
    logic             frameOnProc;
    logic [4:0]       excNum;
    logic [4:0]       pendExc;
    logic             reqOut;
    logic             start;
    logic [1:0]       power;
    logic             sleepReq;
    logic             wake;
    logic [31:0]      popWord;
    logic             popValid;
  } core_state_type;

  phase_type      phase_q;
  phase_type      phase_d;
  core_state_type state_q;
  core_state_type state_d;

  stack_mem_if memBus ();

  stack_port u_stack_port (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .bus      (memBus.port),
    .memReq   (memReq),
    .memWrite (memWrite),
    .memAddr  (memAddr),
    .memWdata (memWdata),
    .memAck   (memAck),
    .memRdata (memRdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [IRQ_N-1:0] irqSync;
  logic             wdogSync;
  logic             fixedSync;
  logic [IRQ_N-1:0] serviceable;
  logic             anyIrq;
  logic [4:0]       firstIrq;
  logic             wakeSource;
  logic [FRAME_W-1:0] pushData;
  logic             useProc;

  assign irqSync   = state_q.syncB[IRQ_N-1:0];
  assign wdogSync  = state_q.syncB[IRQ_N];
  assign fixedSync = state_q.syncB[IRQ_N+1];

  // Configurable sources are held off by the global mask but left pending
  assign serviceable = irqSync & irqEnable & ~(irqConfigurable & {IRQ_N{globalMaskBit}});

  always_comb begin
    anyIrq   = 1'b0;
    firstIrq = 5'h00;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (serviceable[i]) begin
        anyIrq   = 1'b1;
        firstIrq = 5'(i);
      end
    end
  end

  // Deep-Sleep wakes only on enabled interrupts or the watchdog; fixed sources count only while not deep
  always_comb begin
    wakeSource = 1'b0;
    case (state_q.power)
      exc_pkg::PWR_SLEEP: wakeSource = (|(irqSync & irqEnable)) | wdogSync | fixedSync;
      exc_pkg::PWR_DEEP:  wakeSource = (|(irqSync & irqEnable)) | wdogSync;
      default:            wakeSource = 1'b0;
    endcase
  end

  always_comb begin
    case (exc_pkg::slot_type'(state_q.slot))
      exc_pkg::SLOT_STATUS:  pushData = statusIn;
      exc_pkg::SLOT_RETADDR: pushData = retAddrIn;
      exc_pkg::SLOT_LINK:    pushData = linkIn;
      exc_pkg::SLOT_R12:     pushData = r12In;
      exc_pkg::SLOT_R3:      pushData = r3In;
      exc_pkg::SLOT_R2:      pushData = r2In;
      exc_pkg::SLOT_R1:      pushData = r1In;
      default:               pushData = r0In;
    endcase
  end

  // Only thread mode honours the select bit; nesting always lands on main
  assign useProc = ~state_q.handler & spSelect;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d          = state_q;
    phase_d          = phase_q;
    state_d.syncA    = {fixedIrq, watchdogIrq, irqPending};
    state_d.syncB    = state_q.syncA;
    state_d.reqOut   = 1'b0;
    state_d.start    = 1'b0;
    state_d.sleepReq = 1'b0;
    state_d.wake     = 1'b0;
    state_d.popValid = 1'b0;

    if (vtBaseWrite) begin
      state_d.vtBase = vtBaseData;
    end
    if (spWrite && phase_q == ST_IDLE) begin
      if (spWriteProc) begin
        state_d.processSp = spWriteData;
      end else begin
        state_d.mainSp = spWriteData;
      end
    end

    case (phase_q)
      ST_IDLE: begin
        if (state_q.power != exc_pkg::PWR_ACTIVE) begin
          if (wakeSource) begin
            state_d.power = exc_pkg::PWR_ACTIVE;
            state_d.wake  = 1'b1;
          end
        end else if (anyIrq && state_q.depth != 3'h7) begin
          // Frame claimed up front; words then fill from the top down
          state_d.excNum      = firstIrq;
          state_d.frameOnProc = useProc;
          state_d.slot        = 3'(exc_pkg::FRAME_WORDS - 1);
          if (useProc) begin
            state_d.frameBase = state_q.processSp - exc_pkg::FRAME_BYTES;
          end else begin
            state_d.frameBase = state_q.mainSp - exc_pkg::FRAME_BYTES;
          end
          phase_d = ST_PUSH;
        end else if (excReturn && state_q.handler) begin
          state_d.slot = 3'h0;
          phase_d      = ST_POP;
        end else if (waitForInterrupt) begin
          state_d.power    = deepSleepSelect ? exc_pkg::PWR_DEEP : exc_pkg::PWR_SLEEP;
          state_d.sleepReq = 1'b1;
        end
      end
      ST_PUSH: begin
        state_d.reqOut = 1'b1;
        phase_d        = ST_WAITPUSH;
      end
      ST_WAITPUSH: begin
        if (memBus.done) begin
          if (state_q.slot == 3'h0) begin
            phase_d = ST_ENTER;
          end else begin
            state_d.slot = state_q.slot - 3'h1;
            phase_d      = ST_PUSH;
          end
        end
      end
      ST_ENTER: begin
        // SP now addresses r0, the last word pushed
        if (state_q.frameOnProc) begin
          state_d.processSp = state_q.frameBase;
        end else begin
          state_d.mainSp = state_q.frameBase;
        end
        state_d.handler = 1'b1;
        state_d.depth   = state_q.depth + 3'h1;
        state_d.start   = 1'b1;
        phase_d         = ST_IDLE;
      end
      ST_POP: begin
        state_d.reqOut = 1'b1;
        phase_d        = ST_WAITPOP;
      end
      ST_WAITPOP: begin
        if (memBus.done) begin
          state_d.popWord  = memBus.rdata;
          state_d.popValid = 1'b1;
          if (state_q.slot == 3'(exc_pkg::FRAME_WORDS - 1)) begin
            // Return to thread only when the outermost handler unwinds
            if (state_q.depth == 3'h1) begin
              state_d.handler = 1'b0;
              state_d.excNum  = 5'h00;
            end
            if (state_q.depth == 3'h1 && spSelect) begin
              state_d.processSp = state_q.processSp + exc_pkg::FRAME_BYTES;
            end else begin
              state_d.mainSp = state_q.mainSp + exc_pkg::FRAME_BYTES;
            end
            state_d.depth = state_q.depth - 3'h1;
            phase_d       = ST_IDLE;
          end else begin
            state_d.slot = state_q.slot + 3'h1;
            phase_d      = ST_POP;
          end
        end
      end
      default: phase_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q          <= ST_IDLE;
      state_q          <= '0;
      state_q.mainSp   <= exc_pkg::SP_RESET;
      state_q.processSp <= exc_pkg::SP_RESET;
      state_q.power    <= exc_pkg::PWR_ACTIVE;
    end else begin
      phase_q <= phase_d;
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pop frame pointer: outermost return from thread on process uses process SP
  logic [31:0] popSp;
  assign popSp = (state_q.depth == 3'h1 && spSelect) ? state_q.processSp : state_q.mainSp;

  assign memBus.req   = state_q.reqOut;
  assign memBus.write = (phase_q == ST_WAITPUSH);
  assign memBus.addr  = (phase_q == ST_WAITPUSH)
                        ? state_q.frameBase + {27'h0, state_q.slot, 2'h0}
                        : popSp + {27'h0, state_q.slot, 2'h0};
  assign memBus.wdata = pushData;

  assign handlerMode  = state_q.handler;
  assign mainSp       = state_q.mainSp;
  assign processSp    = state_q.processSp;
  assign activeSp     = (~state_q.handler & spSelect) ? state_q.processSp : state_q.mainSp;
  assign vectorAddr   = {state_q.vtBase, 28'h0} + ({27'h0, state_q.excNum} << 2);
  assign activeExc    = state_q.excNum;
  assign handlerStart = state_q.start;
  assign powerMode    = state_q.power;
  assign sleepRequest = state_q.sleepReq;
  assign wakeup       = state_q.wake;
  assign popWord      = state_q.popWord;
  assign popValid     = state_q.popValid;

endmodule : exception_stacking_and_wakeup

// ### design/stack_port.sv
`timescale 1ns/10ps
module stack_port (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  stack_mem_if.port        bus,
  output      logic        memReq,
  output      logic        memWrite,
  output      logic [31:0] memAddr,
  output      logic [31:0] memWdata,
  input  wire logic        memAck,
  input  wire logic [31:0] memRdata
);

  typedef struct packed {
    logic        busy;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        done;
  } port_state_type;

  port_state_type state_q;
  port_state_type state_d;

  always_comb begin
    state_d      = state_q;
    state_d.done = 1'b0;
    if (state_q.busy) begin
      if (memAck) begin
        state_d.busy  = 1'b0;
        state_d.done  = 1'b1;
        state_d.rdata = memRdata;
      end
    end else if (bus.req) begin
      state_d.busy  = 1'b1;
      state_d.write = bus.write;
      state_d.addr  = bus.addr;
      state_d.wdata = bus.wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign memReq     = state_q.busy;
  assign memWrite   = state_q.write;
  assign memAddr    = state_q.addr;
  assign memWdata   = state_q.wdata;
  assign bus.rdata  = state_q.rdata;
  assign bus.done   = state_q.done;

endmodule : stack_port

// ### dv/exc_monitor.sv
`timescale 1ns/10ps
module exc_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        spSelect,
  input wire logic        deepSleepSelect,
  input wire logic        waitForInterrupt,
  input wire logic        vtBaseWrite,
  input wire logic [3:0]  vtBaseData,
  input wire logic        memReq,
  input wire logic        memWrite,
  input wire logic [31:0] memAddr,
  input wire logic        memAck,
  input wire logic        handlerMode,
  input wire logic [31:0] activeSp,
  input wire logic [31:0] mainSp,
  input wire logic [31:0] processSp,
  input wire logic [31:0] vectorAddr,
  input wire logic        handlerStart,
  input wire logic [1:0]  powerMode,
  input wire logic        sleepRequest,
  input wire logic        wakeup
);
  logic [4:0]  wrCnt_q;
  logic [4:0]  rdCnt_q;
  logic [31:0] lastWr_q;
  logic        wrProc_q;
  // Pop count spans nested returns, so only whole frames are required
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrCnt_q  <= 5'h00;
      rdCnt_q  <= 5'h00;
      lastWr_q <= 32'h0000_0000;
      wrProc_q <= 1'b0;
    end else begin
      wrCnt_q  <= handlerStart ? 5'h00 : wrCnt_q + 5'(memAck && memWrite);
      rdCnt_q  <= !handlerMode ? 5'h00 : rdCnt_q + 5'(memAck && !memWrite);
      lastWr_q <= (memAck && memWrite) ? memAddr : lastWr_q;
      // Thread frames follow the select bit; nested frames always sit on main
      wrProc_q <= (memAck && memWrite) ? (!handlerMode && spSelect) : wrProc_q;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wfiReq;
    waitForInterrupt && powerMode == exc_pkg::PWR_ACTIVE && !handlerMode && !memReq;
  endsequence
  sequence s_sleepGo;
    sleepRequest && powerMode == ($past(deepSleepSelect) ? exc_pkg::PWR_DEEP : exc_pkg::PWR_SLEEP);
  endsequence
  property p_wfiEntry; s_wfiReq |=> s_sleepGo; endproperty
  property p_frameCount; handlerStart |-> wrCnt_q == 5'h08 && !memReq; endproperty
  property p_oneActive; activeSp == mainSp || activeSp == processSp; endproperty
  property p_threadSel; !handlerMode |-> activeSp == (spSelect ? processSp : mainSp); endproperty
  property p_handlerMain; handlerMode && !memReq |-> activeSp == mainSp; endproperty
  property p_nestedMain;
    memReq && memWrite && handlerMode |-> memAddr < mainSp && memAddr >= mainSp - 32'h20;
  endproperty
  property p_spLastPush; handlerStart |-> lastWr_q == (wrProc_q ? processSp : mainSp); endproperty
  property p_wakeActive;
    wakeup |-> powerMode == exc_pkg::PWR_ACTIVE && $past(powerMode) != exc_pkg::PWR_ACTIVE;
  endproperty
  property p_vtBase; vtBaseWrite |=> vectorAddr[31:28] == $past(vtBaseData); endproperty
  property p_popCount; $fell(handlerMode) |-> rdCnt_q != 5'h00 && rdCnt_q[2:0] == 3'h0; endproperty
  a_wfiEntry: assert property (p_wfiEntry) else $error("no sleep entry");
  a_frameCount: assert property (p_frameCount) else $error("handler before 8 pushes");
  a_oneActive: assert property (p_oneActive) else $error("active pointer unknown");
  a_threadSel: assert property (p_threadSel) else $error("thread pointer select");
  a_handlerMain: assert property (p_handlerMain) else $error("handler not on main");
  a_nestedMain: assert property (p_nestedMain) else $error("nested push off main");
  a_spLastPush: assert property (p_spLastPush) else $error("pointer not at last push");
  a_wakeActive: assert property (p_wakeActive) else $error("wake without active");
  a_vtBase: assert property (p_vtBase) else $error("vector base not loaded");
  a_popCount: assert property (p_popCount) else $error("partial frame popped");
endmodule : exc_monitor
bind exception_stacking_and_wakeup exc_monitor mon (.clk, .sys_rst, .spSelect, .deepSleepSelect,
  .waitForInterrupt, .vtBaseWrite, .vtBaseData, .memReq, .memWrite, .memAddr, .memAck,
  .handlerMode, .activeSp, .mainSp, .processSp, .vectorAddr, .handlerStart, .powerMode,
  .sleepRequest, .wakeup);

// ### dv/exception_stacking_and_wakeup_tb.sv
`timescale 1ns/10ps
module exception_stacking_and_wakeup_tb;
  localparam logic [31:0] PAT = 32'hC0DE_0000;
  logic clk = 1'b0, sys_rst = 1'b1, spSelect = 1'b0, globalMaskBit = 1'b0, vtBaseWrite = 1'b0;
  logic spWrite = 1'b0, spWriteProc = 1'b0, excReturn = 1'b0, waitForInterrupt = 1'b0;
  logic deepSleepSelect = 1'b0, watchdogIrq = 1'b0, fixedIrq = 1'b0, slowMem = 1'b0;
  logic [3:0]  vtBaseData = 4'h0;
  logic [31:0] spWriteData = 32'h0;
  logic [15:0] irqPending = 16'h0, irqEnable = 16'hFFFF, irqConfigurable = 16'h0;
  logic memReq, memWrite, memAck, handlerMode, handlerStart, sleepRequest, wakeup, popValid;
  logic [31:0] memAddr, memWdata, memRdata, activeSp, mainSp, processSp, vectorAddr, popWord;
  logic [1:0]  powerMode;
  logic [4:0]  activeExc;
  int n_mismatch = 0, num_checks = 0;
  always #2 clk = ~clk;
  exception_stacking_and_wakeup DUT (.clk, .sys_rst, .statusIn(PAT + 32'h7),
    .retAddrIn(PAT + 32'h6), .linkIn(PAT + 32'h5), .r12In(PAT + 32'h4), .r3In(PAT + 32'h3),
    .r2In(PAT + 32'h2), .r1In(PAT + 32'h1), .r0In(PAT), .spSelect, .globalMaskBit,
    .vtBaseWrite, .vtBaseData, .spWrite, .spWriteProc, .spWriteData, .excReturn,
    .waitForInterrupt, .deepSleepSelect, .irqPending, .irqEnable, .irqConfigurable,
    .watchdogIrq, .fixedIrq, .memReq, .memWrite, .memAddr, .memWdata, .memAck, .memRdata,
    .handlerMode, .activeSp, .mainSp, .processSp, .vectorAddr, .activeExc, .handlerStart,
    .powerMode, .sleepRequest, .wakeup, .popWord, .popValid);
  stack_mem_model farSide (.clk, .slow(slowMem), .memReq, .memWrite, .memAddr, .memWdata,
    .memAck, .memRdata);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Pulses are one cycle wide, so the level is taken just after each edge
  task automatic waitHi(input int sel);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 300 && hit !== 1'b1; i++) begin
      @(posedge clk) #1;
      hit = (sel == 0) ? handlerStart : (sel == 1) ? popValid : wakeup;
    end
    check({31'h0, hit}, 32'h1);
  endtask : waitHi
  // Sources are levels: drop the line once stacking has begun, or entry repeats
  task automatic drop(input int idx);
    @(negedge clk);
    for (int i = 0; i < 40 && memReq !== 1'b1; i++) @(negedge clk);
    irqPending[idx] = 1'b0;
  endtask : drop
  task automatic spLoad(input logic proc, input logic [31:0] d);
    @(negedge clk) {spWrite, spWriteProc, spWriteData} = {1'b1, proc, d};
    @(negedge clk) spWrite = 1'b0;
  endtask : spLoad
  task automatic enter(input logic [31:0] fb, input int idx);
    @(negedge clk) irqPending[idx] = 1'b1;
    drop(idx);
    waitHi(0);
    check({27'h0, activeExc}, 32'(idx));
    check(vectorAddr, 32'hA000_0000 + 32'(4 * idx));
    for (int s = 0; s < 8; s++) check(farSide.store[fb + 32'(4 * s)], PAT + 32'(s));
  endtask : enter
  task automatic retn();
    @(negedge clk) excReturn = 1'b1;
    @(negedge clk) excReturn = 1'b0;
    for (int k = 0; k < 8; k++) begin
      waitHi(1);
      check(popWord, PAT + 32'(k));
    end
    for (int i = 0; i < 20 && handlerMode === 1'b1; i++) @(posedge clk) #1;
  endtask : retn
  task automatic wait_for_interrupt_instruction(input logic deep, input logic [1:0] mode);
    @(negedge clk) {waitForInterrupt, deepSleepSelect} = {1'b1, deep};
    @(posedge clk) #1;
    check({29'h0, powerMode, sleepRequest}, {29'h0, mode, 1'b1});
    @(negedge clk) waitForInterrupt = 1'b0;
  endtask : wait_for_interrupt_instruction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_vt();
    @(negedge clk) {vtBaseWrite, vtBaseData} = {1'b1, 4'hA};
    @(negedge clk) vtBaseWrite = 1'b0;
    check({28'h0, vectorAddr[31:28]}, 32'hA);
  endtask : t_vt
  task automatic t_main();
    spLoad(1'b0, 32'h2000_1000);
    enter(32'h2000_0FE0, 3);
    check(mainSp, 32'h2000_0FE0);
    enter(32'h2000_0FC0, 1);
    check(activeSp, 32'h2000_0FC0);
    retn();
    check({31'h0, handlerMode}, 32'h1);
    check(mainSp, 32'h2000_0FE0);
    retn();
    check({mainSp[30:0], handlerMode}, {31'h2000_1000, 1'b0});
  endtask : t_main
  task automatic t_proc();
    @(negedge clk) {slowMem, spSelect} = 2'b11;
    spLoad(1'b1, 32'h2000_0800);
    enter(32'h2000_07E0, 5);
    check(processSp, 32'h2000_07E0);
    check(activeSp, 32'h2000_1000);
    retn();
    check(activeSp, 32'h2000_0800);
    @(negedge clk) {slowMem, spSelect} = 2'b00;
  endtask : t_proc
  task automatic t_mask();
    @(negedge clk) {globalMaskBit, irqConfigurable[2], irqPending[2]} = 3'b111;
    repeat (40) @(posedge clk);
    check({30'h0, handlerMode, memReq}, 32'h0);
    @(negedge clk) globalMaskBit = 1'b0;
    drop(2);
    waitHi(0);
    check({27'h0, activeExc}, 32'h2);
    retn();
  endtask : t_mask
  task automatic t_sleep();
    wait_for_interrupt_instruction(1'b0, 2'h1);
    @(negedge clk) irqPending[4] = 1'b1;
    waitHi(2);
    check({30'h0, powerMode}, 32'h0);
    drop(4);
    waitHi(0);
    check({27'h0, activeExc}, 32'h4);
    retn();
    wait_for_interrupt_instruction(1'b1, 2'h2);
    @(negedge clk) fixedIrq = 1'b1;
    repeat (20) @(posedge clk);
    check({30'h0, powerMode}, 32'h2);
    @(negedge clk) {fixedIrq, watchdogIrq} = 2'b01;
    waitHi(2);
    check({30'h0, powerMode}, 32'h0);
  endtask : t_sleep
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    t_vt();
    t_main();
    t_proc();
    t_mask();
    t_sleep();
    tally_and_finish();
  end
  initial begin
    #60000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : exception_stacking_and_wakeup_tb

// ### dv/stack_mem_model.sv
`timescale 1ns/10ps
module stack_mem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        memReq,
  input  wire logic        memWrite,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  output      logic        memAck,
  output      logic [31:0] memRdata
);
  logic [31:0] store [logic [31:0]];
  logic [1:0]  wait_q = 2'h0;
  initial memAck = 1'b0;
  initial memRdata = 32'h0;
  // Read data is inverted every idle cycle so a stale sample never looks right
  always @(posedge clk) begin
    if (memReq && !memAck && wait_q >= (slow ? 2'h3 : 2'h0)) begin
      memAck <= 1'b1;
      wait_q <= 2'h0;
      if (memWrite) store[memAddr] = memWdata;
      else memRdata <= store.exists(memAddr) ? store[memAddr] : 32'h0;
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq && !memAck) wait_q <= wait_q + 2'h1;
    end
  end
endmodule : stack_mem_model
